// ===== src/sensor_regs_pkg.sv
// Shared constants for the command pointer and control register front end.
// Assumes a serial bus engine on the same clock that delivers whole bytes.
package sensor_regs_pkg;

    typedef enum logic [1:0] {
        TR_BYTE  = 2'b00,
        TR_WORD  = 2'b01,
        TR_BLOCK = 2'b10,
        TR_ICLR  = 2'b11
    } trans_t;

    localparam logic [4:0] CTRL_ADDR   = 5'h00;
    localparam logic [4:0] TIMING_ADDR = 5'h01;
    localparam logic [4:0] ALIAS_ADDR  = 5'h0F;
    localparam logic [4:0] DATA_BASE   = 5'h10;
    localparam logic [4:0] DATA_LAST   = 5'h17;

    localparam int CMD_BIT    = 7;
    localparam int TRANS_MSB  = 6;
    localparam int TRANS_LSB  = 5;
    localparam int ADDR_MSB   = 4;
    localparam int CTRL_PWR   = 0;
    localparam int CTRL_EN    = 1;
    localparam int CTRL_VALID = 4;

    localparam logic [7:0] POINTER_RST  = 8'h00;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    localparam logic [7:0] TIMING_RST   = 8'h00;
    localparam logic [7:0] BLOCK_COUNT  = 8'h08;

endpackage

// ===== src/command_decode.sv
// Splits a received byte into the command fields.
// Assumes the byte is held stable by the caller while it is used.
`timescale 1ns/1ps
module command_decode (
    input  wire logic                   [7:0] byte_i,
    output sensor_regs_pkg::trans_t           trans_o,
    output logic                        [4:0] addr_o,
    output logic                              is_cmd_o
);
    assign is_cmd_o = byte_i[sensor_regs_pkg::CMD_BIT];
    assign trans_o  = sensor_regs_pkg::trans_t'(byte_i[sensor_regs_pkg::TRANS_MSB:sensor_regs_pkg::TRANS_LSB]);
    assign addr_o   = byte_i[sensor_regs_pkg::ADDR_MSB:0];
endmodule

// ===== src/read_select.sv
// Registered read data path for the register map and channel data.
// Assumes the caller pulses req_i once per byte the bus engine asks for.
`timescale 1ns/1ps
module read_select (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        req_i,
    input  wire logic        count_i,
    input  wire logic [4:0]  addr_i,
    input  wire logic [7:0]  ctrl_i,
    input  wire logic [7:0]  timing_i,
    input  wire logic [63:0] ch_data_i,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o
);
    logic [7:0] sel;

    always_comb begin
        sel = 8'h00;
        if (count_i) begin
            sel = sensor_regs_pkg::BLOCK_COUNT;
        end else if (addr_i == sensor_regs_pkg::CTRL_ADDR) begin
            sel = ctrl_i;
        end else if (addr_i == sensor_regs_pkg::TIMING_ADDR) begin
            sel = timing_i;
        end else if (addr_i >= sensor_regs_pkg::DATA_BASE && addr_i <= sensor_regs_pkg::DATA_LAST) begin
            sel = ch_data_i[8*addr_i[2:0] +: 8];
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            rd_valid_o <= req_i;
            if (req_i) begin
                rd_data_o <= sel;
            end
        end
    end
endmodule

// ===== src/sensor_command_control_regs.sv
// Command pointer, control and timing registers of the colour sensor.
// Assumes a byte-level serial engine on clk_i: start, stop, written bytes, read requests.
//
// Function
// - Bits 6:5 pick byte, word, block
// - Transaction 11 pulses interrupt clear
// - Bits 4:0 address following data bytes
// - Command pointer resets to zero
// - Plain block transfers increment until stop
// - SMBus block writes carry byte count; block reads only at the alias
// - Alias block read returns count eight
// - Control bit 4 reports integration done
// - Control bit 1 enables converters
// - Control bit 0 powers device
// - Converters run only with both set
// - Control reads back written 03h; reads 13h once bit 4 sets
// - Oscillator forced on during transfers
// - Timing register shared, resets to zero
// - First byte after start with MSB one updates pointer
// - Receive byte returns pointed register
`timescale 1ns/1ps
module sensor_command_control_regs #(
    parameter bit SMBUS_MODE = 1'b1
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        start_i,
    input  wire logic        stop_i,
    input  wire logic        wr_valid_i,
    input  wire logic [7:0]  wr_data_i,
    input  wire logic        rd_req_i,
    input  wire logic        conv_done_i,
    input  wire logic [63:0] ch_data_i,
    output logic      [7:0]  rd_data_o,
    output logic             rd_valid_o,
    output logic      [7:0]  timing_o,
    output logic             adc_run_o,
    output logic             osc_en_o,
    output logic             int_clear_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FIRST,
        ST_COUNT,
        ST_DATA
    } state_t;

    state_t                   state_r;
    sensor_regs_pkg::trans_t  trans_r;
    logic [4:0]               ptr_addr_r;
    logic [4:0]               cur_addr_r;
    logic                     frame_r;
    logic                     count_sent_r;
    logic                     pwr_r;
    logic                     en_r;
    logic                     valid_r;
    logic [7:0]               timing_r;
    logic                     iclr_r;
    logic                     adc_run_r;
    logic                     osc_r;

    sensor_regs_pkg::trans_t  dec_trans;
    logic [4:0]               dec_addr;
    logic                     dec_cmd;
    logic                     take_cmd;
    logic                     data_wr;
    logic [4:0]               eff_addr;
    logic                     send_count;
    logic                     advance;
    logic [7:0]               ctrl_view;

    command_decode u_decode (
        .byte_i   (wr_data_i),
        .trans_o  (dec_trans),
        .addr_o   (dec_addr),
        .is_cmd_o (dec_cmd)
    );

    // Only the first byte after a start can be a command; later bytes are data
    assign take_cmd   = wr_valid_i && (state_r == ST_FIRST) && dec_cmd;
    assign data_wr    = wr_valid_i && !take_cmd && (state_r == ST_FIRST || state_r == ST_DATA);
    // The alias reads as the first data byte so the walk continues at 11h
    assign eff_addr   = (cur_addr_r == sensor_regs_pkg::ALIAS_ADDR) ? sensor_regs_pkg::DATA_BASE : cur_addr_r;
    assign send_count = SMBUS_MODE && (trans_r == sensor_regs_pkg::TR_BLOCK)
                        && (cur_addr_r == sensor_regs_pkg::ALIAS_ADDR) && !count_sent_r;
    assign advance    = (trans_r == sensor_regs_pkg::TR_WORD) || (trans_r == sensor_regs_pkg::TR_BLOCK);
    assign ctrl_view  = {3'b000, valid_r, 2'b00, en_r, pwr_r};

    // Frame sequencing
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            frame_r <= 1'b0;
        end else if (stop_i) begin
            state_r <= ST_IDLE;
            frame_r <= 1'b0;
        end else if (start_i) begin
            state_r <= ST_FIRST;
            frame_r <= 1'b1;
        end else begin
            case (state_r)
                ST_FIRST: begin
                    if (take_cmd && SMBUS_MODE && dec_trans == sensor_regs_pkg::TR_BLOCK) begin
                        state_r <= ST_COUNT;
                    end else if (wr_valid_i || rd_req_i) begin
                        state_r <= ST_DATA;
                    end
                end
                ST_COUNT: begin
                    if (wr_valid_i || rd_req_i) begin
                        state_r <= ST_DATA; // Byte count ignored; the stop ends the block
                    end
                end
                ST_DATA: begin
                    state_r <= ST_DATA;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Stored pointer survives frames; clear commands leave the transaction type alone
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ptr_addr_r <= sensor_regs_pkg::POINTER_RST[4:0];
            trans_r    <= sensor_regs_pkg::trans_t'(sensor_regs_pkg::POINTER_RST[6:5]);
        end else if (take_cmd) begin
            ptr_addr_r <= dec_addr;
            if (dec_trans != sensor_regs_pkg::TR_ICLR) begin
                trans_r <= dec_trans;
            end
        end
    end

    // Working address for this frame
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur_addr_r   <= 5'h00;
            count_sent_r <= 1'b0;
        end else if (start_i) begin
            cur_addr_r   <= ptr_addr_r;
            count_sent_r <= 1'b0;
        end else if (take_cmd) begin
            cur_addr_r   <= dec_addr;
            count_sent_r <= 1'b0;
        end else if (rd_req_i && send_count) begin
            count_sent_r <= 1'b1;
        end else if ((rd_req_i || data_wr) && advance) begin
            cur_addr_r <= eff_addr + 5'h01;
        end
    end

    // Interrupt clear is a one-cycle pulse, never stored
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            iclr_r <= 1'b0;
        end else begin
            iclr_r <= take_cmd && (dec_trans == sensor_regs_pkg::TR_ICLR);
        end
    end

    // Control bits; reserved bits are dropped on write and read as zero
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pwr_r <= sensor_regs_pkg::CTRL_RST[sensor_regs_pkg::CTRL_PWR];
            en_r  <= sensor_regs_pkg::CTRL_RST[sensor_regs_pkg::CTRL_EN];
        end else if (data_wr && cur_addr_r == sensor_regs_pkg::CTRL_ADDR) begin
            pwr_r <= wr_data_i[sensor_regs_pkg::CTRL_PWR];
            en_r  <= wr_data_i[sensor_regs_pkg::CTRL_EN];
        end
    end

    // Completion flag: a done event in the same cycle as a disable still sets it
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            valid_r <= sensor_regs_pkg::CTRL_RST[sensor_regs_pkg::CTRL_VALID];
        end else if (conv_done_i && adc_run_r) begin
            valid_r <= 1'b1;
        end else if (!adc_run_r) begin
            valid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timing_r <= sensor_regs_pkg::TIMING_RST;
        end else if (data_wr && cur_addr_r == sensor_regs_pkg::TIMING_ADDR) begin
            timing_r <= wr_data_i;
        end
    end

    // Power and enable gate the converters; serial activity keeps the oscillator alive
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            adc_run_r <= 1'b0;
            osc_r     <= 1'b0;
        end else begin
            adc_run_r <= pwr_r && en_r;
            osc_r     <= pwr_r || frame_r || start_i;
        end
    end

    read_select u_read (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .req_i      (rd_req_i),
        .count_i    (send_count),
        .addr_i     (eff_addr),
        .ctrl_i     (ctrl_view),
        .timing_i   (timing_r),
        .ch_data_i  (ch_data_i),
        .rd_data_o  (rd_data_o),
        .rd_valid_o (rd_valid_o)
    );

    assign timing_o    = timing_r;
    assign adc_run_o   = adc_run_r;
    assign osc_en_o    = osc_r;
    assign int_clear_o = iclr_r;

endmodule

// ===== testbench/sensor_regs_chk.sv
// Port assertions for the command pointer and control register block.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
module sensor_regs_chk (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        start_i,
    input wire logic        stop_i,
    input wire logic        wr_valid_i,
    input wire logic [7:0]  wr_data_i,
    input wire logic        rd_req_i,
    input wire logic        conv_done_i,
    input wire logic [63:0] ch_data_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        rd_valid_o,
    input wire logic [7:0]  timing_o,
    input wire logic        adc_run_o,
    input wire logic        osc_en_o,
    input wire logic        int_clear_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_read_answer: assert property (rd_req_i |=> rd_valid_o)
        else $error("read request got no answer");
    a_read_source: assert property (rd_valid_o |-> $past(rd_req_i))
        else $error("read answer without request");
    a_read_hold: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data moved without answer");
    a_clear_cause: assert property (int_clear_o |-> $past(wr_valid_i && wr_data_i[7:5] == 3'b111))
        else $error("interrupt clear without clear command");
    a_osc_frame: assert property (start_i && !stop_i |=> osc_en_o)
        else $error("oscillator off inside a frame");
    a_run_needs_osc: assert property (adc_run_o |-> osc_en_o)
        else $error("converters run with power off");
    a_run_by_write: assert property ($changed(adc_run_o) |-> $past(wr_valid_i, 2))
        else $error("converter run changed without a write");
    a_timing_by_write: assert property ($changed(timing_o) |-> $past(wr_valid_i))
        else $error("timing changed without a write");
    c_clear: cover property (int_clear_o);
    c_count: cover property (rd_valid_o && rd_data_o == 8'h08);
    c_run: cover property (adc_run_o);
endmodule

bind sensor_command_control_regs sensor_regs_chk u_chk (.clk_i, .nrst_i, .start_i, .stop_i, .wr_valid_i,
    .wr_data_i, .rd_req_i, .conv_done_i, .ch_data_i, .rd_data_o, .rd_valid_o, .timing_o, .adc_run_o,
    .osc_en_o, .int_clear_o);

// ===== testbench/host_model.sv
// Bus host seen through the byte engine: frames, bytes and read requests.
// Assumes the engine hands whole bytes on the same clock; drives on falling edges.
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rd_data_i,
    output logic            start_o = 1'b0,
    output logic            stop_o = 1'b0,
    output logic            wr_valid_o = 1'b0,
    output logic      [7:0] wr_data_o = 8'h00,
    output logic            rd_req_o = 1'b0
);
    task automatic start;
        @(negedge clk_i) start_o = 1'b1;
        @(negedge clk_i) start_o = 1'b0;
    endtask
    task automatic stop;
        @(negedge clk_i) stop_o = 1'b1;
        @(negedge clk_i) stop_o = 1'b0;
    endtask
    // Data is inverted after release so a stale byte is never reused
    task automatic wr(input logic [7:0] d);
        @(negedge clk_i) wr_valid_o = 1'b1;
        wr_data_o = d;
        @(negedge clk_i) wr_valid_o = 1'b0;
        wr_data_o = ~d;
    endtask
    task automatic rd(output logic [7:0] d);
        @(negedge clk_i) rd_req_o = 1'b1;
        @(negedge clk_i) rd_req_o = 1'b0;
        d = rd_data_i;
    endtask
    // Byte writes only; never aimed at the alias address
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        start;
        wr({3'b100, a});
        wr(d);
        stop;
    endtask
    // Send-byte frame alone clears interrupts
    task automatic clear(input logic [4:0] a);
        start;
        wr({3'b111, a});
        stop;
    endtask
endmodule

// ===== testbench/testbench.sv
// Self-checking bench: host model makes frames, a byte model predicts reads.
// Assumes the design's default SMBus variant.
`timescale 1ns/1ps
module testbench;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        conv_done_i = 1'b0;
    logic [63:0] ch_data_i = 64'h0;
    logic        start_i, stop_i, wr_valid_i, rd_req_i, rd_valid_o, adc_run_o, osc_en_o, int_clear_o;
    logic [7:0]  wr_data_i, rd_data_o, timing_o, ctrl_m, tim_m, ptr_m, b;
    logic        vld_m;
    logic [7:0]  q[$];
    integer      seed = 95;
    integer      failures = 0;
    integer      cmp_count = 0;
    integer      cyc = 0;
    integer      clr_seen = 0;

    initial forever #20 clk_i = ~clk_i;

    sensor_command_control_regs u_sensor_command_control_regs (.clk_i, .nrst_i, .start_i, .stop_i,
        .wr_valid_i, .wr_data_i, .rd_req_i, .conv_done_i, .ch_data_i, .rd_data_o, .rd_valid_o, .timing_o,
        .adc_run_o, .osc_en_o, .int_clear_o);
    host_model u_host (.clk_i, .rd_data_i(rd_data_o), .start_o(start_i), .stop_o(stop_i),
        .wr_valid_o(wr_valid_i), .wr_data_o(wr_data_i), .rd_req_o(rd_req_i));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic logic [7:0] expv(input logic [4:0] a);
        if (a == 5'h00) return {3'b000, vld_m, 2'b00, ctrl_m[1:0]};
        if (a == 5'h01) return tim_m;
        if (a[4:3] == 2'b10) return ch_data_i[8*a[2:0] +: 8];
        return 8'h00;
    endfunction
    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        u_host.write_reg(a, d);
        ptr_m = {3'b100, a};
        if (a == 5'h01) tim_m = d;
        if (a == 5'h00) ctrl_m = d;
        if (ctrl_m[1:0] != 2'b11) vld_m = 1'b0;
    endtask
    // Optional command, repeated start, then n reads checked against the model
    task automatic rdn(input logic [7:0] c, input int n);
        logic [4:0] a;
        u_host.start;
        if (c[7]) ptr_m = c;
        if (c[7]) u_host.wr(c);
        if (c[7]) u_host.start;
        a = ptr_m[4:0];
        if (c == 8'hCF) q.push_back(8'h08);
        if (c == 8'hCF) a = 5'h10;
        repeat (n) begin
            q.push_back(expv(a));
            if (ptr_m[6:5] != 2'b00) a++;
        end
        while (q.size() > 0) begin
            u_host.rd(b);
            chk(b, q.pop_front());
        end
        u_host.stop;
    endtask
    task automatic model_reset;
        ctrl_m = 8'h00;
        tim_m = 8'h00;
        ptr_m = 8'h00;
        vld_m = 1'b0;
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (int_clear_o) clr_seen++;
        if (cyc == 20000) begin
            failures++;
            conclude;
        end
    end

    initial begin
        ch_data_i = {$random(seed), $random(seed)};
        model_reset;
        repeat (2) @(negedge clk_i);
        nrst_i = 1'b1;
        chk(timing_o, 8'h00);
        rdn(8'h00, 1);
        // The stop edge still sees the frame flag, so the oscillator drops one edge later
        @(negedge clk_i);
        chk({7'h00, osc_en_o}, 8'h00);
        b = 8'($random(seed));
        wreg(5'h01, b);
        chk(timing_o, tim_m);
        wreg(5'h00, 8'h01);
        chk({7'h00, adc_run_o}, 8'h00);
        wreg(5'h00, 8'h03);
        chk({7'h00, adc_run_o}, 8'h01);
        rdn(8'h80, 1);
        @(negedge clk_i) conv_done_i = 1'b1;
        @(negedge clk_i) conv_done_i = 1'b0;
        vld_m = 1'b1;
        rdn(8'h00, 2);
        wreg(5'h00, 8'h02);
        chk({7'h00, adc_run_o}, 8'h00);
        // A done pulse while the converters are stopped must not set the flag
        @(negedge clk_i) conv_done_i = 1'b1;
        @(negedge clk_i) conv_done_i = 1'b0;
        rdn(8'hBF, 2);
        rdn(8'hD0, 3);
        rdn(8'hCF, 8);
        // Block write: the count byte is skipped, then the target walks 00h, 01h
        u_host.start;
        u_host.wr(8'hC0);
        u_host.wr(8'h02);
        b = 8'($random(seed));
        u_host.wr(8'h02);
        u_host.wr(b);
        u_host.stop;
        ptr_m = 8'hC0;
        tim_m = b;
        chk(timing_o, tim_m);
        rdn(8'h00, 2);
        u_host.start;
        chk({7'h00, osc_en_o}, 8'h01);
        u_host.stop;
        @(negedge clk_i);
        chk({7'h00, osc_en_o}, 8'h00);
        clr_seen = 0;
        u_host.clear(5'h01);
        chk(8'(clr_seen), 8'h01);
        ptr_m[4:0] = 5'h01;
        rdn(8'h00, 1);
        @(negedge clk_i) nrst_i = 1'b0;
        @(negedge clk_i) nrst_i = 1'b1;
        model_reset;
        chk(timing_o, 8'h00);
        rdn(8'h00, 1);
        conclude;
    end
endmodule
